/* hdl/memory_addressing_unit.sv */
// Program counter, return stack and banked data address generation
//
// Notes on behaviour
// - Program counter is 11 bits, covering all 2K program words.
// - Power-on reset loads program counter with 0x000.
// - Software interrupt sends execution to 0x001.
// - Any accepted hardware interrupt sends execution to 0x008.
// - Short jump and short call reach only 256 locations.
// - Long call and long jump reach any program address.
// - Calls and interrupts push the next instruction address.
// - All three returns pop the top entry into the program counter.
// - Rolling code words are fetched and executed like normal code.
// - Three data spaces decoded: general, config and peripheral.
// - General space has four banks chosen by status bits 7 and 6.
// - Indirect port access uses pointer low seven bits within selected bank.
// - Direct access uses opcode low seven bits within selected bank.
// - General special registers need no dedicated access instruction.
// - General special registers live at 0x00 to 0x1F of bank 0.
// - Special register addresses in banks 1 to 3 land in bank 0.
// - RAM only in bank 0 and bank 1 low half; others fold back.
// - Config and peripheral spaces ignore the bank field.
`timescale 1ns/10ps
module memory_addressing_unit
(
    input  wire logic               CLK,
    input  wire logic               RESET,
    input  wire mau_pkg::pc_req_s   PC_REQ,
    input  wire mau_pkg::data_req_s DATA_REQ,
    input  wire logic [7:0]         STATUS_VALUE,
    input  wire logic [7:0]         POINTER_VALUE,
    output logic [10:0]             PC,
    output mau_pkg::data_acc_s      DATA_ACC,
    output logic [3:0]              STACK_LEVEL
);

    // ****************************************
    // Program counter decode
    // ****************************************
    logic [10:0]        pc_reg;
    logic [10:0]        pc_next;
    logic [10:0]        pc_plus;
    logic [10:0]        short_target;
    logic [10:0]        stack_top;
    logic               is_call;
    logic               is_return;
    logic               push;
    logic               pop;
    logic [2:0]         ptr_reg;
    logic [2:0]         ptr_next;
    logic [2:0]         top_next;
    logic [3:0]         depth_reg;
    logic [3:0]         depth_next;

    assign pc_plus = pc_reg + mau_pkg::PC_ONE;

    assign short_target = {pc_plus[mau_pkg::PC_W-1:mau_pkg::SHORT_W],
                           PC_REQ.target[mau_pkg::SHORT_W-1:0]};

    assign is_call   = (PC_REQ.op == mau_pkg::PC_SHORT_CALL) ||
                       (PC_REQ.op == mau_pkg::PC_LONG_CALL)  ||
                       (PC_REQ.op == mau_pkg::PC_SW_INT)     ||
                       (PC_REQ.op == mau_pkg::PC_HW_INT);
    assign is_return = (PC_REQ.op == mau_pkg::PC_RET)     ||
                       (PC_REQ.op == mau_pkg::PC_RET_LIT) ||
                       (PC_REQ.op == mau_pkg::PC_RET_INT);
    assign push      = PC_REQ.step && is_call;
    assign pop       = PC_REQ.step && is_return;

    always_comb
    begin
        pc_next = pc_reg;
        if (PC_REQ.step)
        begin
            case (PC_REQ.op)
                mau_pkg::PC_HOLD:       pc_next = pc_reg;
                mau_pkg::PC_SEQ:        pc_next = pc_plus;
                mau_pkg::PC_SHORT_JUMP: pc_next = short_target;
                mau_pkg::PC_SHORT_CALL: pc_next = short_target;
                mau_pkg::PC_LONG_JUMP:  pc_next = PC_REQ.target;
                mau_pkg::PC_LONG_CALL:  pc_next = PC_REQ.target;
                mau_pkg::PC_RET:        pc_next = stack_top;
                mau_pkg::PC_RET_LIT:    pc_next = stack_top;
                mau_pkg::PC_RET_INT:    pc_next = stack_top;
                mau_pkg::PC_SW_INT:     pc_next = mau_pkg::SW_INT_VEC;
                mau_pkg::PC_HW_INT:     pc_next = mau_pkg::HW_INT_VEC;
                default:                pc_next = pc_reg;
            endcase
        end
    end

    // ****************************************
    // Return stack pointer
    // ****************************************
    // ring of eight, oldest overwritten
    assign ptr_next = push ? ptr_reg + mau_pkg::PTR_STEP :
                      pop  ? ptr_reg - mau_pkg::PTR_STEP : ptr_reg;
    assign top_next = ptr_next - mau_pkg::PTR_STEP;
    assign depth_next = (push && (depth_reg != mau_pkg::STK_FULL))  ?
                            depth_reg + mau_pkg::STK_STEP :
                        (pop && (depth_reg != mau_pkg::STK_EMPTY)) ?
                            depth_reg - mau_pkg::STK_STEP : depth_reg;

    return_stack_ram u_stack
    (
        .clk     (CLK),
        .reset   (RESET),
        .wr_en   (push),
        .wr_addr (ptr_reg),
        .wr_data (pc_plus),
        .rd_addr (top_next),
        .rd_data (stack_top)
    );

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pc_reg    <= mau_pkg::RESET_VEC;
            ptr_reg   <= mau_pkg::PTR_RESET;
            depth_reg <= mau_pkg::STK_EMPTY;
        end
        else
        begin
            pc_reg    <= pc_next;
            ptr_reg   <= ptr_next;
            depth_reg <= depth_next;
        end
    end

    // ****************************************
    // Data address decode
    // ****************************************
    logic [1:0]         bank_select_field;
    logic               indirect;
    logic [6:0]         gen_loc;
    logic               gen_sfr;
    logic               phys_bank1;
    logic [7:0]         gen_addr;
    logic [7:0]         side_addr;
    mau_pkg::data_acc_s acc_next;
    mau_pkg::data_acc_s acc_reg;

    assign bank_select_field = STATUS_VALUE[mau_pkg::BANK_MSB:mau_pkg::BANK_LSB];
    assign indirect = (DATA_REQ.loc == mau_pkg::INDIRECT_LOC);

    assign gen_loc = indirect ? POINTER_VALUE[mau_pkg::LOC_W-1:0] : DATA_REQ.loc;

    // all banks fold to bank 0
    assign gen_sfr = (gen_loc < mau_pkg::SFR_LIMIT);

    // only banks 1 and 3 low half reach bank 1 RAM
    assign phys_bank1 = !gen_sfr && (gen_loc < mau_pkg::LOW_LIMIT) &&
                        ((bank_select_field == mau_pkg::BANK1) ||
                         (bank_select_field == mau_pkg::BANK3));
    assign gen_addr  = {phys_bank1, gen_loc};

    assign side_addr = {1'b0, DATA_REQ.loc};

    always_comb
    begin
        acc_next.valid     = DATA_REQ.valid;
        acc_next.write     = DATA_REQ.write;
        acc_next.space     = DATA_REQ.space;
        acc_next.is_sfr    = 1'b0;
        acc_next.phys_addr = side_addr;
        case (DATA_REQ.space)
            mau_pkg::SP_GENERAL:
            begin
                acc_next.is_sfr    = gen_sfr;
                acc_next.phys_addr = gen_addr;
            end
            mau_pkg::SP_CONFIG:  acc_next.phys_addr = side_addr;
            mau_pkg::SP_PERIPH:  acc_next.phys_addr = side_addr;
            default:             acc_next.valid = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            acc_reg <= '0;
        else
            acc_reg <= acc_next;
    end

    assign PC          = pc_reg;
    assign DATA_ACC    = acc_reg;
    assign STACK_LEVEL = depth_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_step(mau_pkg::pc_op_e op);
        PC_REQ.step && (PC_REQ.op == op);
    endsequence

    sequence s_call;
        PC_REQ.step && (PC_REQ.op == mau_pkg::PC_LONG_CALL);
    endsequence

    sequence s_ret;
        PC_REQ.step && (PC_REQ.op == mau_pkg::PC_RET);
    endsequence

    sequence s_gen_req;
        DATA_REQ.valid && (DATA_REQ.space == mau_pkg::SP_GENERAL);
    endsequence

    property p_reset_vec;
        $fell(RESET) |-> (PC == mau_pkg::RESET_VEC);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

    property p_sw_vec;
        s_step(mau_pkg::PC_SW_INT) |=> (PC == mau_pkg::SW_INT_VEC);
    endproperty
    a_sw_vec: assert property (p_sw_vec) else $error("software vector wrong");

    property p_hw_vec;
        s_step(mau_pkg::PC_HW_INT) |=> (PC == mau_pkg::HW_INT_VEC) &&
            ($changed(STACK_LEVEL) || (STACK_LEVEL == mau_pkg::STK_FULL));
    endproperty
    a_hw_vec: assert property (p_hw_vec) else $error("hardware vector wrong");

    property p_short;
        s_step(mau_pkg::PC_SHORT_JUMP) |=>
            (PC[mau_pkg::SHORT_W-1:0] == $past(PC_REQ.target[mau_pkg::SHORT_W-1:0])) &&
            (PC[mau_pkg::PC_W-1:mau_pkg::SHORT_W] == $past(pc_plus[mau_pkg::PC_W-1:mau_pkg::SHORT_W]));
    endproperty
    a_short: assert property (p_short) else $error("short jump target wrong");

    property p_long;
        s_step(mau_pkg::PC_LONG_JUMP) |=> (PC == $past(PC_REQ.target));
    endproperty
    a_long: assert property (p_long) else $error("long jump target wrong");

    property p_call_ret;
        s_call ##1 s_ret |=> (PC == $past(pc_plus, 2));
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address wrong");

    property p_seq;
        s_step(mau_pkg::PC_SEQ) |=> (PC == $past(pc_plus));
    endproperty
    a_seq: assert property (p_seq) else $error("sequential fetch wrong");

    property p_depth;
        ((STACK_LEVEL == mau_pkg::STK_FULL) and s_call) |=> (STACK_LEVEL == mau_pkg::STK_FULL);
    endproperty
    a_depth: assert property (p_depth) else $error("stack depth exceeded");

    property p_push_level;
        push && (STACK_LEVEL != mau_pkg::STK_FULL) |=>
            (STACK_LEVEL == $past(STACK_LEVEL) + mau_pkg::STK_STEP);
    endproperty
    a_push_level: assert property (p_push_level) else $error("push did not deepen stack");

    property p_pop_level;
        pop && (STACK_LEVEL != mau_pkg::STK_EMPTY) |=>
            (STACK_LEVEL == $past(STACK_LEVEL) - mau_pkg::STK_STEP);
    endproperty
    a_pop_level: assert property (p_pop_level) else $error("pop did not shrink stack");

    property p_indirect;
        s_gen_req ##0 (DATA_REQ.loc == mau_pkg::INDIRECT_LOC) |=>
            (DATA_ACC.phys_addr[mau_pkg::LOC_W-1:0] == $past(POINTER_VALUE[mau_pkg::LOC_W-1:0]));
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect location wrong");

    property p_sfr_fold;
        s_gen_req ##0 ((DATA_REQ.loc != mau_pkg::INDIRECT_LOC) &&
            (DATA_REQ.loc < mau_pkg::SFR_LIMIT)) |=> DATA_ACC.is_sfr && !DATA_ACC.phys_addr[7];
    endproperty
    a_sfr_fold: assert property (p_sfr_fold) else $error("special register not bank 0");

    property p_low_ram;
        s_gen_req ##0 ((DATA_REQ.loc >= mau_pkg::SFR_LIMIT) &&
            (DATA_REQ.loc < mau_pkg::LOW_LIMIT)) |=>
            (DATA_ACC.phys_addr[7] == $past(STATUS_VALUE[mau_pkg::BANK_LSB])) && !DATA_ACC.is_sfr;
    endproperty
    a_low_ram: assert property (p_low_ram) else $error("low half bank fold wrong");

    property p_direct_high;
        s_gen_req ##0 (DATA_REQ.loc >= mau_pkg::LOW_LIMIT) |=>
            (DATA_ACC.phys_addr == {1'b0, $past(DATA_REQ.loc)});
    endproperty
    a_direct_high: assert property (p_direct_high) else $error("direct location wrong");

    property p_side;
        DATA_REQ.valid && (DATA_REQ.space != mau_pkg::SP_GENERAL) |=>
            (DATA_ACC.phys_addr == {1'b0, $past(DATA_REQ.loc)}) && !DATA_ACC.is_sfr;
    endproperty
    a_side: assert property (p_side) else $error("side space address wrong");

endmodule

/* hdl/return_stack_ram.sv */
// Eight-entry return address memory with registered read and write bypass
`timescale 1ns/10ps
module return_stack_ram
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [10:0] wr_data,
    input  wire logic [2:0]  rd_addr,
    output logic      [10:0] rd_data
);

    logic [10:0] mem [0:mau_pkg::STK_ENTRIES-1];

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // Bypass so a pop right after a push sees the new word
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rd_data <= mau_pkg::RESET_VEC;
        else if (wr_en && (wr_addr == rd_addr))
            rd_data <= wr_data;
        else
            rd_data <= mem[rd_addr];
    end

endmodule

/* shared/mau_pkg.sv */
// Constants and carrier types for the program and data memory addressing unit
package mau_pkg;

    // ****************************************
    // Program counter and vectors
    // ****************************************
    localparam int          PC_W        = 11;
    localparam logic [10:0] PC_ONE      = 11'h001;
    localparam logic [10:0] RESET_VEC   = 11'h000;
    localparam logic [10:0] SW_INT_VEC  = 11'h001;
    localparam logic [10:0] HW_INT_VEC  = 11'h008;
    localparam int          SHORT_W     = 8;
    localparam logic [10:0] RESERVED_LO = 11'h7fe;
    localparam logic [10:0] ROLLING_LO  = 11'h00e;

    // ****************************************
    // Return stack
    // ****************************************
    localparam int          STK_PTR_W   = 3;
    localparam int          STK_ENTRIES = 8;
    localparam logic [3:0]  STK_FULL    = 4'h8;
    localparam logic [3:0]  STK_EMPTY   = 4'h0;
    localparam logic [3:0]  STK_STEP    = 4'h1;
    localparam logic [2:0]  PTR_STEP    = 3'h1;
    localparam logic [2:0]  PTR_RESET   = 3'h0;

    // ****************************************
    // Data space
    // ****************************************
    localparam int          LOC_W       = 7;
    localparam int          BANK_MSB    = 7;
    localparam int          BANK_LSB    = 6;
    localparam logic [6:0]  INDIRECT_LOC = 7'h00;
    localparam logic [6:0]  SFR_LIMIT   = 7'h20;
    localparam logic [6:0]  LOW_LIMIT   = 7'h40;
    localparam logic [1:0]  BANK1       = 2'h1;
    localparam logic [1:0]  BANK3       = 2'h3;

    typedef enum logic [3:0] {
        PC_HOLD       = 4'b0000,
        PC_SEQ        = 4'b0001,
        PC_SHORT_JUMP = 4'b0010,
        PC_SHORT_CALL = 4'b0011,
        PC_LONG_JUMP  = 4'b0100,
        PC_LONG_CALL  = 4'b0101,
        PC_RET        = 4'b0110,
        PC_RET_LIT    = 4'b0111,
        PC_RET_INT    = 4'b1000,
        PC_SW_INT     = 4'b1001,
        PC_HW_INT     = 4'b1010
    } pc_op_e;

    typedef enum logic [1:0] {
        SP_GENERAL = 2'b00,
        SP_CONFIG  = 2'b01,
        SP_PERIPH  = 2'b10
    } space_e;

    typedef struct packed {
        logic        step;
        pc_op_e      op;
        logic [10:0] target;
    } pc_req_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        space_e     space;
        logic [6:0] loc;
    } data_req_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        space_e     space;
        logic       is_sfr;
        logic [7:0] phys_addr;
    } data_acc_s;

endpackage

/* verification/core_model.sv */
// Stand-in for the execution core that issues program and data requests
`timescale 1ns/10ps
module core_model
(
    input  wire logic          clk,
    output mau_pkg::pc_req_s   pc_req,
    output mau_pkg::data_req_s data_req,
    output logic [7:0]         status_value,
    output logic [7:0]         pointer_value,
    output logic               bad_target
);
    // ****************************************
    // Request drivers, each request held one cycle
    // ****************************************
    initial
    begin
        pc_req        = '0;
        data_req      = '0;
        status_value  = 8'h00;
        pointer_value = 8'h00;
        bad_target    = 1'b0;
    end

    task automatic pc_op(input mau_pkg::pc_op_e op, input logic [10:0] target);
        pc_req = '{step: 1'b1, op: op, target: target};
        @(negedge clk);
    endtask

    task automatic data_op(input logic wr, input logic [1:0] sp, input logic [6:0] loc,
                           input logic [7:0] st, input logic [7:0] ptr);
        data_req      = '{valid: 1'b1, write: wr, space: mau_pkg::space_e'(sp), loc: loc};
        status_value  = st;
        pointer_value = ptr;
        @(negedge clk);
    endtask

    // Released target, write, loc and pointer show the inverse of their last value; space and status keep theirs
    task automatic idle();
        pc_req        = '{step: 1'b0, op: mau_pkg::PC_HOLD, target: ~pc_req.target};
        data_req      = '{valid: 1'b0, write: ~data_req.write, space: data_req.space,
                          loc: ~data_req.loc};
        pointer_value = ~pointer_value;
        @(negedge clk);
    endtask

    always @(posedge clk)
        if (pc_req.step && pc_req.op inside {mau_pkg::PC_LONG_JUMP, mau_pkg::PC_LONG_CALL}
            && pc_req.target >= mau_pkg::RESERVED_LO)
            bad_target <= 1'b1;
endmodule

/* verification/test_memory_addressing_unit.sv */
// Self-checking bench for the program and data addressing unit
`timescale 1ns/10ps
module test_memory_addressing_unit;
    logic               clk;
    logic               reset;
    mau_pkg::pc_req_s   pc_req;
    mau_pkg::data_req_s data_req;
    logic [7:0]         status_value;
    logic [7:0]         pointer_value;
    logic               bad_target;
    logic [10:0]        pc;
    mau_pkg::data_acc_s data_acc;
    logic [3:0]         stack_level;
    int                 n_mismatch = 0;
    int                 tests_run  = 0;
    int                 cycles     = 0;

    core_model i_core (.clk(clk), .pc_req(pc_req), .data_req(data_req),
        .status_value(status_value), .pointer_value(pointer_value), .bad_target(bad_target));

    memory_addressing_unit i_dut (.CLK(clk), .RESET(reset), .PC_REQ(pc_req),
        .DATA_REQ(data_req), .STATUS_VALUE(status_value), .POINTER_VALUE(pointer_value),
        .PC(pc), .DATA_ACC(data_acc), .STACK_LEVEL(stack_level));

    // ****************************************
    // Clock, timeout and reporting
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_pc(input logic [10:0] exp_pc, input logic [3:0] exp_lvl);
        check("pc", 16'(exp_pc), 16'(pc));
        check("stack_level", 16'(exp_lvl), 16'(stack_level));
    endtask

    task automatic go(input mau_pkg::pc_op_e op, input logic [10:0] target);
        i_core.pc_op(op, target);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk_pc(11'h000, 4'h0); // reset vector
        check("acc", 16'h0000, 16'(data_acc)); // reset clears access
        reset = 1'b0;
        i_core.idle();
        chk_pc(11'h000, 4'h0); // reset vector
    endtask

    task automatic t_seq_long();
        go(mau_pkg::PC_LONG_JUMP, 11'h00d);
        chk_pc(11'h00d, 4'h0); // long reach
        go(mau_pkg::PC_SEQ, 11'h000);
        chk_pc(11'h00e, 4'h0); // rolling words fetched
        go(mau_pkg::PC_SEQ, 11'h000);
        chk_pc(11'h00f, 4'h0); // rolling words fetched
        go(mau_pkg::PC_LONG_JUMP, 11'h7fd);
        chk_pc(11'h7fd, 4'h0); // full width
        i_core.idle();
        chk_pc(11'h7fd, 4'h0); // held without step
    endtask

    task automatic t_ints();
        go(mau_pkg::PC_LONG_JUMP, 11'h123);
        go(mau_pkg::PC_SW_INT, 11'h456);
        chk_pc(11'h001, 4'h1); // software vector
        go(mau_pkg::PC_HW_INT, 11'h456);
        chk_pc(11'h008, 4'h2); // hardware vector
        go(mau_pkg::PC_RET_INT, 11'h456);
        chk_pc(11'h002, 4'h1); // pop on return
        go(mau_pkg::PC_RET_LIT, 11'h456);
        chk_pc(11'h124, 4'h0); // next address pushed
    endtask

    task automatic t_short();
        go(mau_pkg::PC_LONG_JUMP, 11'h2ff);
        go(mau_pkg::PC_SHORT_JUMP, 11'h6ab);
        chk_pc(11'h3ab, 4'h0); // page of next address
        go(mau_pkg::PC_SHORT_CALL, 11'h510);
        chk_pc(11'h310, 4'h1); // short call reach
        go(mau_pkg::PC_RET, 11'h000);
        chk_pc(11'h3ac, 4'h0); // pop on return
        go(mau_pkg::PC_LONG_CALL, 11'h456);
        chk_pc(11'h456, 4'h1); // long call reach
        go(mau_pkg::PC_RET, 11'h000);
        chk_pc(11'h3ad, 4'h0); // next address pushed
    endtask

    task automatic t_stack();
        for (int i = 0; i < 9; i++)
        begin
            go(mau_pkg::PC_LONG_JUMP, 11'h200 + 11'(i * 16));
            go(mau_pkg::PC_LONG_CALL, 11'h050);
            check("stack_level", 16'(i < 8 ? i + 1 : 8), 16'(stack_level)); // depth eight
        end
        for (int j = 8; j > 0; j--)
        begin
            go(mau_pkg::PC_RET, 11'h000);
            chk_pc(11'h201 + 11'(j * 16), 4'(j - 1)); // oldest overwritten
        end
        go(mau_pkg::PC_RET, 11'h000);
        check("stack_level", 16'h0000, 16'(stack_level)); // empty stays empty
        i_core.idle();
    endtask

    task automatic t_data();
        logic [6:0] locs [7] = '{7'h00, 7'h05, 7'h1f, 7'h20, 7'h3f, 7'h40, 7'h7f};
        logic [7:0] ptr;
        logic [6:0] eff;
        logic [7:0] phys;
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 4; b++)
                for (int k = 0; k < 7; k++)
                begin
                    ptr  = b[0] ? 8'ha5 : 8'h9c;
                    eff  = (s == 0 && locs[k] == 7'h00) ? ptr[6:0] : locs[k];
                    phys = {s == 0 && eff >= 7'h20 && eff < 7'h40 && b[0], eff};
                    i_core.data_op(k[0], 2'(s), locs[k], {2'(b), 6'h2a}, ptr);
                    check("valid", 16'(s != 3), 16'(data_acc.valid)); // three spaces
                    if (s != 3)
                    begin
                        check("space", 16'(s), 16'(data_acc.space)); // three spaces
                        check("write", 16'(k[0]), 16'(data_acc.write)); // plain access
                        check("phys", 16'(phys), 16'(data_acc.phys_addr));
                        if (s == 0)
                            check("sfr", 16'(eff < 7'h20), 16'(data_acc.is_sfr)); // bank 0 registers
                    end
                end
        i_core.idle();
    endtask

    task automatic t_reset_mid();
        go(mau_pkg::PC_LONG_CALL, 11'h333);
        chk_pc(11'h333, 4'h1); // long call reach
        reset = 1'b1;
        i_core.idle();
        chk_pc(11'h000, 4'h0); // reset vector
        reset = 1'b0;
        i_core.idle();
        chk_pc(11'h000, 4'h0); // reset vector
    endtask

    initial
    begin
        reset = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        t_reset();
        t_seq_long();
        t_ints();
        t_short();
        t_stack();
        t_data();
        t_reset_mid();
        check("bad_target", 16'h0000, 16'(bad_target)); // reserved words unused
        end_sim();
    end
endmodule
